// file: pkg/dspreg_pkg.sv
// Purpose : Shared constants and carriers for the DSP peripheral register bank
// Assumes : Word-addressed 16-bit core data bus, one clock domain
// Notes   : Offsets are core data-space word addresses
`default_nettype none
package dspreg_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [15:0] HOST_REG_BASE = 16'hc000;
  localparam logic [15:0] HOST_REG_LAST = 16'hc00f;
  localparam logic [15:0] ADR_CAPTURE   = 16'hc010;
  localparam logic [15:0] ADR_SERIAL    = 16'hc011;
  localparam logic [15:0] ADR_REQUEST   = 16'hc012;
  localparam logic [15:0] ADR_RATE_LO   = 16'hc013;
  localparam logic [15:0] ADR_RATE_HI   = 16'hc014;
  localparam logic [15:0] ADR_LEFT      = 16'hc015;
  localparam logic [15:0] ADR_RIGHT     = 16'hc016;
  localparam logic [15:0] ADR_PIN_DIR   = 16'hc017;
  localparam logic [15:0] ADR_PIN_IN    = 16'hc018;
  localparam logic [15:0] ADR_PIN_OUT   = 16'hc019;

  // ----------------------------------------------------------------------
  // Field layout and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CAP_WRITE_BIT  = 4;
  localparam int unsigned RATE_HI_W      = 5;
  localparam int unsigned DOUBLER_BIT    = 4;
  localparam int unsigned ACC_W          = 26;
  localparam int unsigned TICK_DIV       = 4;
  localparam int unsigned GPIO_W         = 4;
  localparam logic [15:0] RESET_VALUE    = 16'h0000;

  // Host control-port access event
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [3:0] index;
  } dspreg_host_acc_s;

  // Core data-bus request
  typedef struct packed {
    logic                rd;
    logic                wr;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } dspreg_bus_req_s;
endpackage
`default_nettype wire

// file: rtl/dspreg_bank.sv
// Purpose : Hardware register space of the embedded DSP core
// Assumes : Inputs synchronous to clk; host register file lives outside
// Notes   : Read data is registered, one cycle after the read strobe
//
// How it works
// - Host registers forwarded at c000..c00f
// - Read-only last host access capture
// - Capture bit 4 set on writes
// - Capture bits 3:0 hold accessed index
// - Serial word, earlier byte in upper half
// - Write bit 0 drives request pin
// - Every fourth cycle add rate increment
// - Overflow loads samples, pulses DAC request
// - Rate-high bit 4 enables clock doubler
// - Rate-low register holds sixteen LSBs
// - Five-bit rate-high register, doubler plus MSBs
// - Left and right sample registers
// - Direction bit one makes pin output
// - Input register reads live pin levels
// - Output register drives output pins
// - Output bits kept while pin is input
// - Pin port raises no interrupt
`default_nettype none
module dspreg_bank
  import dspreg_pkg::*;
#(
  parameter int unsigned ACC_BITS = ACC_W   // Rate accumulator width
) (
  input  wire logic                         clk,            // 50 MHz clock
  input  wire logic                         rst_b,          // Async reset, low
  input  wire dspreg_pkg::dspreg_bus_req_s  bus_req,        // Core bus request
  output logic [dspreg_pkg::DATA_W-1:0]     bus_rdata,      // Registered read data
  output logic                              host_sel,       // Host register access
  output logic [3:0]                        host_index,     // Host register index
  input  wire logic [dspreg_pkg::DATA_W-1:0] host_rdata,    // Host register data
  input  wire dspreg_pkg::dspreg_host_acc_s host_acc,       // Host access event
  input  wire logic                         serial_valid,   // Serial byte strobe
  input  wire logic [7:0]                   serial_byte,    // Serial byte
  output logic                              data_request_pin, // Request pin level
  output logic                              dac_load,       // Sample load pulse
  output logic                              dac_irq,        // DAC request pulse
  output logic [dspreg_pkg::DATA_W-1:0]     dac_left,       // Loaded left sample
  output logic [dspreg_pkg::DATA_W-1:0]     dac_right,      // Loaded right sample
  output logic                              doubler_en,     // Clock doubler enable
  input  wire logic [3:0]                   gpio_in,        // Pin levels
  output logic [3:0]                        gpio_out,       // Pin drive levels
  output logic [3:0]                        gpio_oe         // Pin drive enables
);
  import dspreg_pkg::*;

  // Elaboration guard: the increment is 20 bits wide, so a narrower accumulator would lose them
  if (ACC_BITS < 21 || ACC_BITS > 32) begin : g_acc_bits_check
    $error("ACC_BITS out of range");
  end
  // Tick counter is two bits wide, so only a divide by four is served
  if (TICK_DIV != 4) begin : g_tick_div_check
    $error("TICK_DIV must be four");
  end

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  logic [15:0] addr;
  logic        wr;
  logic        rd;
  logic        wr_request;
  logic        wr_rate_lo;
  logic        wr_rate_hi;
  logic        wr_left;
  logic        wr_right;
  logic        wr_dir;
  logic        wr_out;
  assign addr       = bus_req.addr;
  assign wr         = bus_req.wr;
  assign rd         = bus_req.rd;
  assign host_sel   = (rd | wr) && addr >= HOST_REG_BASE && addr <= HOST_REG_LAST;
  assign host_index = addr[3:0];
  assign wr_request = wr && addr == ADR_REQUEST;
  assign wr_rate_lo = wr && addr == ADR_RATE_LO;
  assign wr_rate_hi = wr && addr == ADR_RATE_HI;
  assign wr_left    = wr && addr == ADR_LEFT;
  assign wr_right   = wr && addr == ADR_RIGHT;
  assign wr_dir     = wr && addr == ADR_PIN_DIR;
  assign wr_out     = wr && addr == ADR_PIN_OUT;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [5:0]           capture;
  logic [15:0]          serial_word;
  logic [15:0]          rate_lo;
  logic [RATE_HI_W-1:0] rate_hi;
  logic [15:0]          left_s;
  logic [15:0]          right_s;
  logic [3:0]           pin_dir;
  logic [3:0]           pin_out;

  // Host access capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture <= 6'h00;
    end else if (host_acc.valid) begin
      capture <= {1'b0, host_acc.write, host_acc.index};
    end
  end

  // Serial shift, newest byte lands low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_word <= RESET_VALUE;
    end else if (serial_valid) begin
      serial_word <= {serial_word[7:0], serial_byte};
    end
  end

  // Request pin level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_request_pin <= 1'b0;
    end else if (wr_request) begin
      data_request_pin <= bus_req.wdata[0];
    end
  end

  // Rate and sample registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_lo <= RESET_VALUE;
      rate_hi <= '0;
      left_s  <= RESET_VALUE;
      right_s <= RESET_VALUE;
    end else begin
      if (wr_rate_lo) rate_lo <= bus_req.wdata;
      if (wr_rate_hi) rate_hi <= bus_req.wdata[RATE_HI_W-1:0];
      if (wr_left)    left_s  <= bus_req.wdata;
      if (wr_right)   right_s <= bus_req.wdata;
    end
  end
  assign doubler_en = rate_hi[DOUBLER_BIT];

  // Pin port; output bits persist regardless of direction, no irq path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_dir <= 4'h0;
      pin_out <= 4'h0;
    end else begin
      if (wr_dir) pin_dir <= bus_req.wdata[GPIO_W-1:0];
      if (wr_out) pin_out <= bus_req.wdata[GPIO_W-1:0];
    end
  end
  assign gpio_oe  = pin_dir;
  assign gpio_out = pin_out & pin_dir;

  // ----------------------------------------------------------------------
  // Rate accumulator
  // ----------------------------------------------------------------------
  logic [1:0]          tick_cnt;
  logic                tick;
  logic [ACC_BITS:0]   acc_sum;
  logic [ACC_BITS-1:0] acc;
  logic [ACC_BITS-1:0] increment;
  assign tick      = tick_cnt == 2'(TICK_DIV - 1);
  assign increment = ACC_BITS'({rate_hi[3:0], rate_lo});
  assign acc_sum   = {1'b0, acc} + {1'b0, increment};

  // Wrap keeps the residue so long-run rate is exact
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 2'h0;
      acc      <= '0;
      dac_load <= 1'b0;
      dac_irq  <= 1'b0;
    end else begin
      tick_cnt <= tick_cnt + 2'h1;
      dac_load <= tick & acc_sum[ACC_BITS];
      dac_irq  <= tick & acc_sum[ACC_BITS];
      if (tick) acc <= acc_sum[ACC_BITS-1:0];
    end
  end

  // Sample latch into the converter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_left  <= RESET_VALUE;
      dac_right <= RESET_VALUE;
    end else if (tick && acc_sum[ACC_BITS]) begin
      dac_left  <= left_s;
      dac_right <= right_s;
    end
  end

  // ----------------------------------------------------------------------
  // Read mux, unmapped and write-only read as zero
  // ----------------------------------------------------------------------
  logic [15:0] rd_mux;
  assign rd_mux = host_sel               ? host_rdata :
                  addr == ADR_CAPTURE    ? {10'h000, capture} :
                  addr == ADR_SERIAL     ? serial_word :
                  addr == ADR_RATE_LO    ? rate_lo :
                  addr == ADR_RATE_HI    ? {11'h000, rate_hi} :
                  addr == ADR_LEFT       ? left_s :
                  addr == ADR_RIGHT      ? right_s :
                  addr == ADR_PIN_DIR    ? {12'h000, pin_dir} :
                  addr == ADR_PIN_IN     ? {12'h000, gpio_in} :
                  addr == ADR_PIN_OUT    ? {12'h000, pin_out} : 16'h0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= RESET_VALUE;
    end else if (rd) begin
      bus_rdata <= rd_mux;
    end
  end
endmodule
`default_nettype wire

// file: bench/dspreg_core_model.sv
// Purpose : Core data-bus master for the register bank
// Assumes : One strobe per access, released at the next edge
// Notes   : Drives only at rising edges, by non-blocking assignment
`default_nettype none
module dspreg_core_model
  import dspreg_pkg::*;
(
  input  wire logic                    clk,     // Core clock
  output var dspreg_pkg::dspreg_bus_req_s bus_req  // Core request
);
  initial bus_req = '0;
  // Single-cycle strobe, then back to idle so no access repeats
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req <= '{1'b0, 1'b1, a, d};
    @(posedge clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    bus_req <= '{1'b1, 1'b0, a, 16'h0000};
    @(posedge clk);
    bus_req <= '0;
  endtask
endmodule
`default_nettype wire

// file: bench/dspreg_bank_properties.sv
// Purpose : Port-level checks of the register bank
// Assumes : One clock, rst_b active low
// Notes   : Bound to every bank instance
`default_nettype none
module dspreg_bank_properties
  import dspreg_pkg::*;
(
  input wire logic                        clk,        // Clock
  input wire logic                        rst_b,      // Reset, low
  input wire dspreg_pkg::dspreg_bus_req_s bus_req,    // Core request
  input wire logic [15:0]                 bus_rdata,  // Read data
  input wire logic                        host_sel,   // Host select
  input wire logic [3:0]                  host_index, // Host index
  input wire logic [3:0]                  gpio_in,    // Pin levels
  input wire logic [3:0]                  gpio_out,   // Pin drive
  input wire logic [3:0]                  gpio_oe,    // Pin enables
  input wire logic                        data_request_pin, // Request pin
  input wire logic                        dac_load,   // Load pulse
  input wire logic                        dac_irq,    // DAC request
  input wire logic [15:0]                 dac_left,   // Loaded left
  input wire logic                        doubler_en  // Doubler
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_host_sel_decode: assert property (host_sel == ((bus_req.rd | bus_req.wr) && bus_req.addr[15:4] == 12'hc00))
    else $error("host select decode wrong");
  a_host_index: assert property (host_sel |-> host_index == bus_req.addr[3:0])
    else $error("host index wrong");
  a_req_pin: assert property (bus_req.wr && bus_req.addr == ADR_REQUEST |=> data_request_pin == $past(bus_req.wdata[0]))
    else $error("request pin not written");
  a_req_read_zero: assert property (bus_req.rd && bus_req.addr == ADR_REQUEST |=> bus_rdata == 16'h0000)
    else $error("write-only register read nonzero");
  a_pin_read: assert property (bus_req.rd && bus_req.addr == ADR_PIN_IN |=> bus_rdata == {12'h000, $past(gpio_in)})
    else $error("pin level read wrong");
  a_dir_write: assert property (bus_req.wr && bus_req.addr == ADR_PIN_DIR |=> gpio_oe == $past(bus_req.wdata[3:0]))
    else $error("pin enable not following direction");
  a_out_masked: assert property ((gpio_out & ~gpio_oe) == 4'h0)
    else $error("input pin driven");
  a_doubler_bit: assert property (bus_req.wr && bus_req.addr == ADR_RATE_HI |=> doubler_en == $past(bus_req.wdata[4]))
    else $error("doubler enable wrong");
  a_irq_load_pair: assert property (dac_irq == dac_load)
    else $error("load and request apart");
  a_irq_spacing: assert property (dac_irq |=> !dac_irq [*3])
    else $error("requests closer than one tick");
  a_left_on_load: assert property ($changed(dac_left) |-> dac_load)
    else $error("left sample moved without load");
endmodule
bind dspreg_bank dspreg_bank_properties dspreg_bank_properties_i (.clk(clk), .rst_b(rst_b), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .host_sel(host_sel), .host_index(host_index), .gpio_in(gpio_in), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe), .data_request_pin(data_request_pin), .dac_load(dac_load), .dac_irq(dac_irq),
  .dac_left(dac_left), .doubler_en(doubler_en));
`default_nettype wire

// file: bench/testbench.sv
// Purpose : Self-checking bench of the register bank
// Assumes : Core model drives the bus, bench drives pins
// Notes   : Read results are checked from a queue of notes
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dspreg_pkg::*;
  logic clk = 0, rst_b = 0, serial_valid = 0, rd_d = 0;
  logic [15:0] host_rdata = 0, bus_rdata, dac_left, dac_right, v, lv, rv;
  logic [7:0]  serial_byte = 0;
  logic [3:0]  gpio_in = 0, host_index, gpio_out, gpio_oe;
  logic        host_sel, data_request_pin, dac_load, dac_irq, doubler_en;
  dspreg_host_acc_s host_acc = '0;
  dspreg_bus_req_s  bus_req;
  int error_cnt = 0, n_compared = 0, cyc = 0, n, t;
  int unsigned seed = 6;
  logic [15:0] expq[$];
  logic [15:0] ra[6] = '{ADR_RATE_LO, ADR_LEFT, ADR_RIGHT, ADR_PIN_DIR, ADR_PIN_OUT, ADR_RATE_HI};
  logic [15:0] rm[6] = '{16'hffff, 16'hffff, 16'hffff, 16'h000f, 16'h000f, 16'h001f};
  always #10 clk = ~clk;
  dspreg_core_model dspreg_core_model_i (.clk(clk), .bus_req(bus_req));
  dspreg_bank dspreg_bank_i (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .host_sel(host_sel), .host_index(host_index), .host_rdata(host_rdata), .host_acc(host_acc),
    .serial_valid(serial_valid), .serial_byte(serial_byte), .data_request_pin(data_request_pin),
    .dac_load(dac_load), .dac_irq(dac_irq), .dac_left(dac_left), .dac_right(dac_right),
    .doubler_en(doubler_en), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdx(logic [15:0] a, logic [15:0] e);
    expq.push_back(e);
    dspreg_core_model_i.rd(a);
  endtask
  // Counts edges up to the next sampled request, bounded
  task automatic gap(output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (dac_irq !== 1'b1 && k < 2000);
  endtask
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Read answers land one cycle after the strobe; cycle ceiling stops hangs
  always @(posedge clk) begin
    rd_d <= bus_req.rd;
    if (rd_d)
      chk("bus_rdata", expq.pop_front(), bus_rdata);
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++) rdx(ra[i], 16'h0000);
    rdx(ADR_CAPTURE, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      dspreg_core_model_i.wr(ra[i], v);
      rdx(ra[i], v & rm[i]);
    end
    dspreg_core_model_i.wr(ADR_RATE_HI, 16'h0000);
    dspreg_core_model_i.wr(ADR_PIN_OUT, 16'h000a);
    dspreg_core_model_i.wr(ADR_PIN_DIR, 16'h0000);
    @(negedge clk) chk("gpio_out", 16'h0000, {12'h0, gpio_out});
    dspreg_core_model_i.wr(ADR_PIN_DIR, 16'h000f);
    @(negedge clk) chk("gpio_out", 16'h000a, {12'h0, gpio_out});
    v = rnd();
    gpio_in <= v[3:0];
    rdx(ADR_PIN_IN, {12'h0, v[3:0]});
    host_rdata <= v;
    rdx(HOST_REG_BASE, v);
    rdx(HOST_REG_LAST, v);
    dspreg_core_model_i.wr(16'hc01f, 16'hffff);
    rdx(16'hc01f, 16'h0000);
    dspreg_core_model_i.wr(ADR_REQUEST, 16'h0001);
    @(negedge clk) chk("data_request_pin", 16'h0001, {15'h0, data_request_pin});
    rdx(ADR_REQUEST, 16'h0000);
    @(posedge clk) host_acc <= '{1'b1, 1'b1, 4'h9};
    @(posedge clk) host_acc <= '{1'b1, 1'b0, 4'h3};
    @(posedge clk) host_acc <= '0;
    dspreg_core_model_i.wr(ADR_CAPTURE, 16'hffff);
    rdx(ADR_CAPTURE, 16'h0003);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) serial_valid <= 1;
      serial_byte <= 8'h5a + 8'(i);
      @(posedge clk) serial_valid <= 0;
    end
    rdx(ADR_SERIAL, 16'h5a5b);
    lv = rnd();
    rv = rnd();
    dspreg_core_model_i.wr(ADR_LEFT, lv);
    dspreg_core_model_i.wr(ADR_RIGHT, rv);
    dspreg_core_model_i.wr(ADR_RATE_LO, 16'h0000);
    dspreg_core_model_i.wr(ADR_RATE_HI, 16'h001c);
    @(negedge clk) chk("doubler_en", 16'h0001, {15'h0, doubler_en});
    gap(n);
    gap(n);
    chk("dac_left", lv, dac_left);
    chk("dac_right", rv, dac_right);
    t = 0;
    for (int i = 0; i < 3; i++) begin
      gap(n);
      t += n;
    end
    chk("three overflow span", 16'd1024, t[15:0]);
    repeat (3) @(posedge clk);
    final_report();
  end
endmodule
`default_nettype wire
